// file: logic/ctio_map.vh
// register offsets, field positions, reset values and timing counts for the
// clock/trigger routing block; included by ctio_top.v and ctio_rate_gen.v
`ifndef CTIO_MAP_VH
`define CTIO_MAP_VH

// apb byte offsets
`define CTIO_OFF_BOARD_CTRL     8'h00
`define CTIO_OFF_BUF_OPS        8'h0C
`define CTIO_OFF_ASSY_CFG       8'h10
`define CTIO_OFF_RATE_A         8'h24
`define CTIO_OFF_RATE_B         8'h28
`define CTIO_OFF_LOAD_STAT      8'h30

// board control word fields
`define CTIO_BCR_CLK_DRV        0
`define CTIO_BCR_TRG_DRV        1
`define CTIO_BCR_EN_RATE_A      5
`define CTIO_BCR_EN_RATE_B      6
`define CTIO_BCR_IRQ_LO         8
`define CTIO_BCR_IRQ_HI         10
`define CTIO_BCR_IRQ_FLAG       11
`define CTIO_BCR_RST            32'h0000_0000

// buffer operations word fields
`define CTIO_BOR_EXT_CLK        0
`define CTIO_BOR_EXT_TRG        1
`define CTIO_BOR_CIRC           8
`define CTIO_BOR_LOAD_REQ       9
`define CTIO_BOR_LOAD_RDY       10
`define CTIO_BOR_RST            32'h0000_0000

// rate generator divisors
`define CTIO_RATE_W             24
`define CTIO_RATE_A_RST         24'h00_00C0
`define CTIO_RATE_B_RST         24'h00_C000

// interrupt event code for end of load ready
`define CTIO_IRQ_END_LOAD       3'h7

// assembly configuration fields
`define CTIO_CFG_CHAN_LO        16
`define CTIO_CFG_SCALE_LO       18
`define CTIO_CFG_FILT_LO        20
`define CTIO_CFG_MCLK_LO        22
`define CTIO_CFG_DISC           24
`define CTIO_MCLK_STD           2'h0

`endif

// file: logic/ctio_rate_gen.v
// rate generator: one-cycle event every divisor clocks of ref_clk_in
// assumes divisor is static while enabled; zero divisor is treated as one
`include "ctio_map.vh"

module ctio_rate_gen #(
   parameter W = `CTIO_RATE_W
) (
   input  wire         ref_clk_in,
   input  wire         sys_rst_in,
   input  wire         enable_in,
   input  wire [W-1:0] divisor_in,
   output reg          tick_out
);

   reg [W-1:0] count_reg;

   always @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         count_reg <= {W{1'b0}};
         tick_out  <= 1'b0;
      end
      else if (!enable_in)
      begin
         count_reg <= {W{1'b0}};
         tick_out  <= 1'b0;
      end
      else if (count_reg + {{(W-1){1'b0}}, 1'b1} >= divisor_in)
      begin
         // event rate = master clock / divisor
         count_reg <= {W{1'b0}};
         tick_out  <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
         tick_out  <= 1'b0;
      end
   end

endmodule // ctio_rate_gen

// file: logic/ctio_top.v
// clock and trigger source routing with shared pins, apb register slave
// assumes apb master on ref_clk_in; shared pins are asynchronous
`include "ctio_map.vh"

module ctio_top #(
   parameter [15:0] FW_REV      = 16'h0001, // arbitrary value
   parameter [1:0]  CHAN_BUILD  = 2'h0,
   parameter [1:0]  SCALE_BUILD = 2'h1,
   parameter [1:0]  FILT_BUILD  = 2'h0,
   parameter        DISC_FIT    = 1'b1
) (
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   input  wire        frame_zero_in,
   input  wire        clk_pin_in,
   output reg         clk_pin_out,
   output reg         clk_pin_oe_out,
   input  wire        shared_burst_pin_in,
   output reg         shared_burst_pin_out,
   output reg         shared_burst_pin_oe_out,
   output reg         dac_clk_out,
   output reg         burst_trig_out,
   output reg         irq_out
);

////////////////////////////////////////////////////////////////////////////////
// registers

   reg  [31:0] board_control_word_reg;
   reg  [31:0] buffer_operations_word_reg;
   reg  [23:0] rate_a_reg;
   reg  [23:0] rate_b_reg;
   reg         load_rdy_d_reg;
   wire [2:0]  irq_sel;
   wire        clk_ext;
   wire        clk_drv;
   wire        trg_ext;
   wire        trg_drv;
   wire        load_rdy;
   wire        tick_a;
   wire        tick_b;

   assign irq_sel  = board_control_word_reg[`CTIO_BCR_IRQ_HI:`CTIO_BCR_IRQ_LO];
   assign clk_drv  = board_control_word_reg[`CTIO_BCR_CLK_DRV];
   assign trg_drv  = board_control_word_reg[`CTIO_BCR_TRG_DRV];
   assign clk_ext  = buffer_operations_word_reg[`CTIO_BOR_EXT_CLK];
   assign trg_ext  = buffer_operations_word_reg[`CTIO_BOR_EXT_TRG];
   assign load_rdy = buffer_operations_word_reg[`CTIO_BOR_LOAD_RDY];

   function [31:0] assy_word;
      input dummy;
      begin
         assy_word = 32'h0000_0000;
         assy_word[15:0] = FW_REV;
         assy_word[`CTIO_CFG_CHAN_LO+1:`CTIO_CFG_CHAN_LO] = CHAN_BUILD;
         assy_word[`CTIO_CFG_SCALE_LO+1:`CTIO_CFG_SCALE_LO] = SCALE_BUILD;
         assy_word[`CTIO_CFG_FILT_LO+1:`CTIO_CFG_FILT_LO] = FILT_BUILD;
         assy_word[`CTIO_CFG_MCLK_LO+1:`CTIO_CFG_MCLK_LO] = `CTIO_MCLK_STD;
         assy_word[`CTIO_CFG_DISC] = DISC_FIT;
         // bits 31:25 stay zero
      end
   endfunction

   // write strobe for one register offset
   function wr_hit;
      input       wr_en;
      input [7:0] addr;
      input [7:0] off;
      begin
         wr_hit = wr_en && (addr == off);
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait state, unmapped reads zero with pslverr

   wire access;
   wire wr;
   reg  mapped;
   reg  [31:0] rd_mux;

   assign access = psel_in & penable_in & ~pready_out;
   // a write lands on the completing edge, the one at which pready is seen
   assign wr     = psel_in & penable_in & pready_out & pwrite_in;

   always @*
   begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr_in)
         `CTIO_OFF_BOARD_CTRL: rd_mux = board_control_word_reg;
         `CTIO_OFF_BUF_OPS:    rd_mux = buffer_operations_word_reg;
         `CTIO_OFF_ASSY_CFG:   rd_mux = assy_word(1'b0);
         `CTIO_OFF_RATE_A:     rd_mux = {8'h00, rate_a_reg};
         `CTIO_OFF_RATE_B:     rd_mux = {8'h00, rate_b_reg};
         default:              mapped = 1'b0;
      endcase
   end

   always @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out  <= access;
         pslverr_out <= access & ~mapped;
         prdata_out  <= (access & ~pwrite_in) ? rd_mux : 32'h0000_0000;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// control registers, load ready and interrupt

   // next values of the control registers
   reg  [31:0] board_control_word_next;
   reg  [31:0] buffer_operations_word_next;
   reg  [23:0] rate_a_next;
   reg  [23:0] rate_b_next;
   wire        wr_bcr;
   wire        wr_bor;
   wire        load_end;
   wire        frame_load;

   assign wr_bcr     = wr_hit(wr, paddr_in, `CTIO_OFF_BOARD_CTRL);
   assign wr_bor     = wr_hit(wr, paddr_in, `CTIO_OFF_BUF_OPS);
   // falling edge of load ready, seen in the first cycle that it reads zero
   assign load_end   = load_rdy_d_reg & ~load_rdy;
   assign frame_load = frame_zero_in & buffer_operations_word_reg[`CTIO_BOR_CIRC]
                       & buffer_operations_word_reg[`CTIO_BOR_LOAD_REQ];

   always @*
   begin
      board_control_word_next = board_control_word_reg;
      if (wr_bcr)
      begin
         // only the routing, enable, selector and flag fields hold state
         board_control_word_next = 32'h0000_0000;
         board_control_word_next[`CTIO_BCR_CLK_DRV]   = pwdata_in[`CTIO_BCR_CLK_DRV];
         board_control_word_next[`CTIO_BCR_TRG_DRV]   = pwdata_in[`CTIO_BCR_TRG_DRV];
         board_control_word_next[`CTIO_BCR_EN_RATE_A] = pwdata_in[`CTIO_BCR_EN_RATE_A];
         board_control_word_next[`CTIO_BCR_EN_RATE_B] = pwdata_in[`CTIO_BCR_EN_RATE_B];
         board_control_word_next[`CTIO_BCR_IRQ_HI:`CTIO_BCR_IRQ_LO] =
            pwdata_in[`CTIO_BCR_IRQ_HI:`CTIO_BCR_IRQ_LO];
         board_control_word_next[`CTIO_BCR_IRQ_FLAG]  = pwdata_in[`CTIO_BCR_IRQ_FLAG];
      end
      // interrupt set wins over a software clear of the flag
      if (irq_sel == `CTIO_IRQ_END_LOAD && load_end)
         board_control_word_next[`CTIO_BCR_IRQ_FLAG] = 1'b1;
   end

   always @*
   begin
      buffer_operations_word_next = buffer_operations_word_reg;
      if (wr_bor)
      begin
         buffer_operations_word_next[`CTIO_BOR_EXT_CLK]  = pwdata_in[`CTIO_BOR_EXT_CLK];
         buffer_operations_word_next[`CTIO_BOR_EXT_TRG]  = pwdata_in[`CTIO_BOR_EXT_TRG];
         buffer_operations_word_next[`CTIO_BOR_CIRC]     = pwdata_in[`CTIO_BOR_CIRC];
         buffer_operations_word_next[`CTIO_BOR_LOAD_REQ] = pwdata_in[`CTIO_BOR_LOAD_REQ];
         // writing one to the load ready position stands for loading finished
         if (pwdata_in[`CTIO_BOR_LOAD_RDY])
            buffer_operations_word_next[`CTIO_BOR_LOAD_RDY] = 1'b0;
      end
      // a frame wrap wins over a software clear in the same cycle
      if (frame_load)
      begin
         buffer_operations_word_next[`CTIO_BOR_LOAD_RDY] = 1'b1;
         buffer_operations_word_next[`CTIO_BOR_LOAD_REQ] = 1'b0;
      end
   end

   always @*
   begin
      rate_a_next = rate_a_reg;
      rate_b_next = rate_b_reg;
      // divisor bits above the generator width read back as zero
      if (wr_hit(wr, paddr_in, `CTIO_OFF_RATE_A))
         rate_a_next = pwdata_in[`CTIO_RATE_W-1:0];
      if (wr_hit(wr, paddr_in, `CTIO_OFF_RATE_B))
         rate_b_next = pwdata_in[`CTIO_RATE_W-1:0];
   end

   always @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         board_control_word_reg     <= `CTIO_BCR_RST;
         buffer_operations_word_reg <= `CTIO_BOR_RST;
         rate_a_reg                 <= `CTIO_RATE_A_RST;
         rate_b_reg                 <= `CTIO_RATE_B_RST;
         load_rdy_d_reg             <= 1'b0;
         irq_out                    <= 1'b0;
      end
      else
      begin
         board_control_word_reg     <= board_control_word_next;
         buffer_operations_word_reg <= buffer_operations_word_next;
         rate_a_reg                 <= rate_a_next;
         rate_b_reg                 <= rate_b_next;
         load_rdy_d_reg             <= load_rdy;
         // irq follows the flag a cycle later
         irq_out                    <= board_control_word_reg[`CTIO_BCR_IRQ_FLAG];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// rate generators

   ctio_rate_gen #(.W(`CTIO_RATE_W)) u_gen_a (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .enable_in  (board_control_word_reg[`CTIO_BCR_EN_RATE_A]),
      .divisor_in (rate_a_reg),
      .tick_out   (tick_a)
   );

   ctio_rate_gen #(.W(`CTIO_RATE_W)) u_gen_b (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .enable_in  (board_control_word_reg[`CTIO_BCR_EN_RATE_B]),
      .divisor_in (rate_b_reg),
      .tick_out   (tick_b)
   );

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and routing

   reg [1:0] clk_sync_reg;
   reg [1:0] trg_sync_reg;
   reg       clk_last_reg;
   reg       trg_last_reg;
   reg       clk_pin_oe_next;
   reg       clk_pin_next;
   reg       trg_pin_oe_next;
   reg       trg_pin_next;
   reg       dac_clk_next;
   reg       burst_trig_next;
   wire      clk_rise;
   wire      trg_rise;

   assign clk_rise = clk_sync_reg[1] & ~clk_last_reg;
   assign trg_rise = trg_sync_reg[1] & ~trg_last_reg;

   // a line is driven only while its driver select stands alone, so two boards
   // never fight over it; both selects set keeps the pin an input
   always @*
   begin
      clk_pin_oe_next = 1'b0;
      clk_pin_next    = 1'b0;
      dac_clk_next    = tick_a;
      case ({clk_ext, clk_drv})
         2'h1:
         begin
            clk_pin_oe_next = 1'b1;
            clk_pin_next    = tick_a;
         end
         2'h2:    dac_clk_next = clk_rise;
         default: dac_clk_next = tick_a;
      endcase
   end

   always @*
   begin
      trg_pin_oe_next = 1'b0;
      trg_pin_next    = 1'b0;
      burst_trig_next = tick_b;
      case ({trg_ext, trg_drv})
         2'h1:
         begin
            trg_pin_oe_next = 1'b1;
            trg_pin_next    = tick_b;
         end
         2'h2:    burst_trig_next = trg_rise;
         default: burst_trig_next = tick_b;
      endcase
   end

   always @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         clk_sync_reg            <= 2'h0;
         trg_sync_reg            <= 2'h0;
         clk_last_reg            <= 1'b0;
         trg_last_reg            <= 1'b0;
         clk_pin_out             <= 1'b0;
         clk_pin_oe_out          <= 1'b0;
         shared_burst_pin_out    <= 1'b0;
         shared_burst_pin_oe_out <= 1'b0;
         dac_clk_out             <= 1'b0;
         burst_trig_out          <= 1'b0;
      end
      else
      begin
         clk_sync_reg <= {clk_sync_reg[0], clk_pin_in};
         trg_sync_reg <= {trg_sync_reg[0], shared_burst_pin_in};
         clk_last_reg <= clk_sync_reg[1];
         trg_last_reg <= trg_sync_reg[1];
         clk_pin_oe_out          <= clk_pin_oe_next;
         clk_pin_out             <= clk_pin_next;
         shared_burst_pin_oe_out <= trg_pin_oe_next;
         shared_burst_pin_out    <= trg_pin_next;
         dac_clk_out             <= dac_clk_next;
         burst_trig_out          <= burst_trig_next;
      end
   end

endmodule // ctio_top

// file: tb/ctio_top_checker.sv
// checker for ctio_top: apb handshake, pin drive and local use of ticks
// assumes a bind to ctio_top, one clock domain and an async high reset
module ctio_chk (
   input wire        ref_clk_in,
   input wire        sys_rst_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [7:0]  paddr_in,
   input wire [31:0] prdata_out,
   input wire        pready_out,
   input wire        pslverr_out,
   input wire        clk_pin_out,
   input wire        clk_pin_oe_out,
   input wire        shared_burst_pin_out,
   input wire        shared_burst_pin_oe_out,
   input wire        dac_clk_out,
   input wire        burst_trig_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_access;
      psel_in && penable_in && !pready_out;
   endsequence
   sequence s_cfg_read;
      pready_out && psel_in && !pwrite_in && paddr_in == 8'h10;
   endsequence
////////////////////////////////////////////////////////////////
   a_ready_next: assert property (s_access |=> pready_out)
      else $error("pready late");
   a_ready_once: assert property (pready_out |=> !pready_out)
      else $error("pready held");
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr alone");
   a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("prdata outside pready");
   a_cfg_reserved: assert property (s_cfg_read |-> prdata_out[26:25] == 2'h0)
      else $error("reserved config bits set");
   a_cfg_mclk: assert property (s_cfg_read |-> prdata_out[23:22] == 2'h0)
      else $error("master clock code wrong");
   a_clk_drive_gated: assert property (clk_pin_out |-> clk_pin_oe_out)
      else $error("clock pin level without enable");
   a_trg_drive_gated: assert property (shared_burst_pin_out |-> shared_burst_pin_oe_out)
      else $error("trigger pin level without enable");
   a_clk_pin_local: assert property (clk_pin_oe_out && clk_pin_out |-> dac_clk_out)
      else $error("driven clock not used locally");
   a_trg_pin_local: assert property (shared_burst_pin_oe_out && shared_burst_pin_out
      |-> burst_trig_out)
      else $error("driven trigger not used locally");
endmodule // ctio_chk

// file: tb/ctio_far_board.sv
// far board: drives the shared clock and trigger lines with a 200 ns wave
// assumes the bench resolves each line from all enables with a pull-down
module ctio_far_board (
   input  wire  run_in,
   input  wire  clk_oe_in,
   input  wire  trg_oe_in,
   output logic clk_out,
   output logic clk_oe_out,
   output logic trg_out,
   output logic trg_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph;
   // phase offset keeps the wave unrelated to the bench clock
   initial
   begin
      ph = 1'b0;
      #37;
      forever #100 ph = ~ph;
   end
   // never fights a board that drives the line
   assign clk_oe_out = run_in && !clk_oe_in;
   assign trg_oe_out = run_in && !trg_oe_in;
   assign clk_out = ph;
   assign trg_out = ph;
endmodule // ctio_far_board

// file: tb/test_ctio_top.sv
// self-checking bench for ctio_top: register rows, pin routing, interrupt
// assumes ctio_top, ctio_far_board and ctio_chk are compiled first
module test_ctio_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CFG = 32'h0116_00A5;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} ctio_row_t;
   logic        clk, rst, psel, pen, pwr, fz, run, e;
   logic [7:0]  addr;
   logic [31:0] wdat, q;
   wire  [31:0] rdat;
   wire         rdy, err, cpo, coe, tpo, toe, dac, trg, irq, fco, fcoe, fto, ftoe;
   wire         cline = coe ? cpo : (fcoe ? fco : 1'b0);
   wire         tline = toe ? tpo : (ftoe ? fto : 1'b0);
   int          fails, check_count;
   logic [31:0] cd, ct, co, cp;
   ctio_row_t   rows[11] = '{
      '{1'b0, 8'h10, 32'h0, CFG, 1'b0},
      '{1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, CFG, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h24, 32'h0, 32'h0000_00C0, 1'b0},
      '{1'b0, 8'h28, 32'h0, 32'h0000_C000, 1'b0},
      '{1'b1, 8'h24, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{1'b0, 8'h24, 32'h0, 32'h00FF_FFFF, 1'b0},
      '{1'b1, 8'h00, 32'h0000_0700, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h0000_0700, 1'b0},
      '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1}};
   ctio_top #(.FW_REV(16'h00A5), .CHAN_BUILD(2'h2), .SCALE_BUILD(2'h1), .FILT_BUILD(2'h1),
      .DISC_FIT(1'b1)) u_dut (.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat),
      .prdata_out(rdat), .pready_out(rdy), .pslverr_out(err), .frame_zero_in(fz),
      .clk_pin_in(cline), .clk_pin_out(cpo), .clk_pin_oe_out(coe),
      .shared_burst_pin_in(tline), .shared_burst_pin_out(tpo),
      .shared_burst_pin_oe_out(toe), .dac_clk_out(dac), .burst_trig_out(trg), .irq_out(irq));
   ctio_far_board u_far (.run_in(run), .clk_oe_in(coe), .trg_oe_in(toe), .clk_out(fco),
      .clk_oe_out(fcoe), .trg_out(fto), .trg_oe_out(ftoe));
////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
      check_count++;
      if (s !== x)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic near(input string nm, input logic [31:0] x, input logic [31:0] s);
      // within two of the expected count passes; unknown bits never do
      chk(nm, x, (s + 2 >= x && s <= x + 2) ? x : s);
   endtask
   // full apb cycle, waits for pready, leaves one idle cycle after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      pen <= 1'b1;
      // ends once pready is seen; only the watchdog ends a wait that hangs
      do @(posedge clk); while (rdy !== 1'b1);
      q = rdat;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("counts: %0d checks, %0d mismatches", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #200us;
      fails++;
      end_of_test();
   end
   initial
   begin
      fails = 0;
      check_count = 0;
      {rst, psel, pen, pwr, fz, run, addr, wdat} = {6'h21, 8'h00, 32'h0};
      repeat (20) @(posedge clk);
      chk("reset outs", 32'h0, {26'h0, coe, toe, irq, rdy, dac, trg});
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk("rdata", rows[i].q, q);
         chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
      end
      $display("register rows done");
      apb(1'b1, 8'h24, 32'h4);
      apb(1'b1, 8'h28, 32'h5);
      run <= 1'b1;
      // modes: 0 internal, 1 drive, 2 external, 3 both selects set
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, 8'h00, (m == 1 || m == 3) ? 32'h63 : 32'h60);
         apb(1'b1, 8'h0C, (m >= 2) ? 32'h3 : 32'h0);
         repeat (20) @(posedge clk);
         {cd, ct, co, cp} = 0;
         repeat (400)
         begin
            @(posedge clk);
            cd += dac;
            ct += trg;
            co += coe + toe;
            cp += cpo + tpo;
         end
         near("dac ticks", (m == 2) ? 50 : 100, cd);
         near("bursts", (m == 2) ? 50 : 80, ct);
         chk("drive cycles", (m == 1) ? 800 : 0, co);
         near("pin ticks", (m == 1) ? 180 : 0, cp);
      end
      $display("routing done");
      apb(1'b1, 8'h00, 32'h0000_0700);
      apb(1'b1, 8'h0C, 32'h0000_0300);
      fz <= 1'b1;
      @(posedge clk);
      fz <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h0C, 32'h0);
      chk("load ready", 32'h0000_0500, q);
      chk("irq on rise", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h0C, 32'h0000_0500);
      repeat (4) @(posedge clk);
      chk("irq on fall", 32'h1, {31'h0, irq});
      apb(1'b0, 8'h00, 32'h0);
      chk("irq flag", 32'h0000_0F00, q);
      apb(1'b1, 8'h00, 32'h0000_0700);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("interrupt done");
      end_of_test();
   end
endmodule // test_ctio_top
bind ctio_top ctio_chk u_chk (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .clk_pin_out, .clk_pin_oe_out,
   .shared_burst_pin_out, .shared_burst_pin_oe_out, .dac_clk_out, .burst_trig_out);
